// ### hdl/frpf_bank.sv
// Purpose: Fault record capture and readback, unset parameter map, peer listen vector
// Assumes: Commands arrive decoded from the management bus on clk_sys; non-volatile
//          storage sits outside and keeps its record across power loss
// Notes:   Every command gets one response pulse on the cycle after it is taken, except one strobed in reset or the first cycle after
`timescale 1ns/1ps
`include "frpf_regs.svh"
module frpf_bank #(
   parameter int FAULT_W = 8
) (
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   input  wire logic                cmd_strobe,
   input  wire logic                cmd_write,
   input  wire logic [7:0]          cmd_code,
   input  wire logic [31:0]         cmd_wdata,
   output      logic                rsp_valid,
   output      logic                rsp_err,
   output      logic [5:0]          rsp_len,
   output      logic [255:0]        rsp_data,
   input  wire logic [255:0]        live_record,
   input  wire logic [15:0]         iout0_meas,
   input  wire logic [FAULT_W-1:0]  fault_event,
   input  wire logic [FAULT_W-1:0]  record_trigger_mask,
   input  wire logic [255:0]        nvm_record,
   input  wire logic                nvm_record_valid,
   output      logic                nvm_store,
   output      logic                nvm_erase,
   output      logic [255:0]        nvm_store_data,
   output      logic                record_frozen,
   input  wire logic                param_recall,
   input  wire logic [127:0]        param_present,
   input  wire logic                param_write,
   input  wire logic [6:0]          param_index,
   input  wire logic                fault_spread_en,
   input  wire logic                sequence_en,
   input  wire logic [31:0]         peer_fault_pin,
   output      logic                peer_shutdown_now,
   output      logic                peer_seq_shutdown,
   output      logic                peer_restart_req,
   input  wire logic                own_output_off,
   input  wire logic                share_all_off,
   output      logic                rail_shutdown
);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter check

   generate
      if (FAULT_W < 1 || FAULT_W > 32) begin : g_bad_fault_w
         $error("frpf_bank: FAULT_W must lie between 1 and 32");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic [255:0]   ram_rec_r;
   logic           frozen_r;
   logic           boot_r;
   logic [127:0]   unset_r;
   logic [31:0]    listen_r;
   logic           store_r;
   logic           erase_r;
   logic           rsp_valid_r;
   logic           rsp_err_r;
   logic [5:0]     rsp_len_r;
   logic [255:0]   rsp_data_r;
   logic [1:0]     off_meta_r;
   logic [1:0]     off_sync_r;
   logic           rail_down_r;

   frpf_peer_if    peer_if ();

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic           rd_cmd;
   logic           wr_cmd;
   logic           hit_record;
   logic           hit_unset;
   logic           hit_listen;
   logic           hit_iout0;
   logic           hit_ctl;
   logic           wr_listen;
   logic           wr_ctl;
   logic [7:0]     ctl_byte;
   logic           ctl_copy;
   logic           ctl_store;
   logic           ctl_erase;
   logic           fault_hit;
   logic           fault_freeze;
   logic           boot_load;
   logic [255:0]   readback_rec;
   logic           bad_access;

   assign rd_cmd     = cmd_strobe && !cmd_write && !boot_r;
   assign wr_cmd     = cmd_strobe &&  cmd_write && !boot_r;
   assign hit_record = (cmd_code == `FRPF_CMD_RECORD);
   assign hit_unset  = (cmd_code == `FRPF_CMD_UNSET_MAP);
   assign hit_listen = (cmd_code == `FRPF_CMD_LISTEN_VEC);
   assign hit_iout0  = (cmd_code == `FRPF_CMD_IOUT0);
   assign hit_ctl    = (cmd_code == `FRPF_CMD_STORE_CTL);
   assign wr_listen  = wr_cmd && hit_listen;
   assign wr_ctl     = wr_cmd && hit_ctl;
   assign ctl_byte   = cmd_wdata[7:0];
   assign ctl_copy   = wr_ctl && (ctl_byte == `FRPF_CTL_COPY_TO_RAM);
   assign ctl_store  = wr_ctl && (ctl_byte == `FRPF_CTL_STORE);
   assign ctl_erase  = wr_ctl && (ctl_byte == `FRPF_CTL_ERASE);

   // Only the first unmasked fault freezes; the stored copy is then kept
   assign fault_hit    = |(fault_event & ~record_trigger_mask);
   assign fault_freeze = fault_hit && !frozen_r && !boot_r;

   // A record that survived power loss is reloaded once after reset
   assign boot_load = boot_r && nvm_record_valid;

   // Status byte tells software where the data came
   always_comb begin
      readback_rec = ram_rec_r;
      readback_rec[`FRPF_NVM_STAT_HI:`FRPF_NVM_STAT_LO] =
         frozen_r ? `FRPF_NVM_STAT_FROZEN : `FRPF_NVM_STAT_LIVE;
   end

   // Writes to read-only commands and codes outside the map are refused
   assign bad_access = cmd_write ? !(hit_listen || (hit_ctl && ctl_byte >= `FRPF_CTL_COPY_TO_RAM
                                                             && ctl_byte <= `FRPF_CTL_ERASE))
                                 : !(hit_record || hit_unset || hit_listen || hit_iout0
                                     || hit_ctl);

   ////////////////////////////////////////////////////////////////////////////////
   // Record capture

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         boot_r <= 1'b1;
      end else begin
         boot_r <= 1'b0;
      end
   end

   // RAM image; kept out of reset so a cleared design starts refreshing at once
   always_ff @(posedge clk_sys) begin
      if (boot_load || ctl_copy) begin
         ram_rec_r <= nvm_record;
      end else if (!frozen_r && !fault_freeze) begin
         ram_rec_r <= live_record;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         frozen_r <= 1'b0;
      end else if (boot_load || fault_freeze || ctl_copy) begin
         frozen_r <= 1'b1;
      end else if (ctl_erase) begin
         frozen_r <= 1'b0;
      end
   end

   // Store pulses; the stored data is the RAM image itself, frozen or still refreshing
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         store_r <= 1'b0;
         erase_r <= 1'b0;
      end else begin
         store_r <= fault_freeze || ctl_store;
         erase_r <= ctl_erase;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Unset parameter map

   // Recall loads the map; a write in the same cycle still clears its bit
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         unset_r <= `FRPF_UNSET_RESET;
      end else begin
         for (int i = 0; i < 128; i++) begin
            if (param_write && param_index == 7'(i)) begin
               unset_r[i] <= 1'b0;
            end else if (param_recall) begin
               unset_r[i] <= ~param_present[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Listen vector and peer reactions

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         listen_r <= `FRPF_LISTEN_RESET;
      end else if (wr_listen) begin
         listen_r <= cmd_wdata;
      end
   end

   assign peer_if.listen_vec     = listen_r;
   assign peer_if.spread_en      = fault_spread_en;
   assign peer_if.seq_en         = sequence_en;
   assign peer_if.peer_fault_pin = peer_fault_pin;

   frpf_peer_ctl u_peer (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pif     (peer_if.ctl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Shared rail shutdown report

   always_ff @(posedge clk_sys) begin
      off_meta_r <= {share_all_off, own_output_off};
      off_sync_r <= off_meta_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rail_down_r <= 1'b0;
      end else begin
         rail_down_r <= off_sync_r[0] && off_sync_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command responses

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rsp_valid_r <= 1'b0;
         rsp_err_r   <= 1'b0;
         rsp_len_r   <= 6'h00;
         rsp_data_r  <= 256'h0;
      end else begin
         rsp_valid_r <= rd_cmd || wr_cmd;
         if (rd_cmd || wr_cmd) begin
            rsp_err_r  <= bad_access;
            rsp_len_r  <= 6'h00;
            rsp_data_r <= 256'h0;
            if (rd_cmd && hit_record) begin
               rsp_len_r  <= `FRPF_LEN_RECORD;
               rsp_data_r <= readback_rec;
            end else if (rd_cmd && hit_unset) begin
               rsp_len_r  <= `FRPF_LEN_UNSET_MAP;
               rsp_data_r <= {128'h0, unset_r};
            end else if (rd_cmd && hit_listen) begin
               rsp_len_r  <= `FRPF_LEN_LISTEN_VEC;
               rsp_data_r <= {224'h0, listen_r};
            end else if (rd_cmd && hit_iout0) begin
               rsp_len_r  <= `FRPF_LEN_IOUT0;
               rsp_data_r <= {240'h0, iout0_meas};
            end else if (rd_cmd && hit_ctl) begin
               rsp_len_r  <= `FRPF_LEN_BYTE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rsp_valid         = rsp_valid_r;
   assign rsp_err           = rsp_err_r;
   assign rsp_len           = rsp_len_r;
   assign rsp_data          = rsp_data_r;
   assign nvm_store         = store_r;
   assign nvm_erase         = erase_r;
   assign nvm_store_data    = ram_rec_r;
   assign record_frozen     = frozen_r;
   assign peer_shutdown_now = peer_if.shutdown_now;
   assign peer_seq_shutdown = peer_if.seq_shutdown;
   assign peer_restart_req  = peer_if.restart_req;
   assign rail_shutdown     = rail_down_r;

endmodule

// ### hdl/frpf_regs.svh
// Purpose: Command codes, control codes and record field positions of the fault record block
// Assumes: Included by bare name; definitions only
// Notes:   Record fields are bit positions inside the 256-bit readback image
//
// Contract
// - Fault record block read returns a 32-byte record of measurements and status.
// - Record refreshes in RAM continuously until frozen, even with output disabled.
// - Unmasked fault stops the refresh and stores the latest record to non-volatile memory.
// - Stored record stays readable after input power is removed and restored.
// - Record bits 183:176 read 0 when frozen, 255 while refreshing.
// - Status bytes sit in bits 175:128, maker-specific byte at top, output voltage lowest.
// - Phase 1, phase 0 currents and external temperature 2 fill the top fields.
// - Record store control command can also store the record to non-volatile memory.
// - Unset parameter map read returns 16 bytes, one bit per unset parameter.
// - Writing a parameter after the last recall clears its unset map bit.
// - Peer fault listen vector is 32 bits, byte 0 bit 0 is group 0.
// - React to a peer fault only when that sender's listen bit is set.
// - Spread mode on: shut down at once, restart after all peers clear.
// - Spread mode off: sequenced shutdown, restart after all group faults clear.
// - Spread and sequencing both off: ignore peer faults and stay enabled.
// - Sharing rail reports shutdown only when every sharing product is down.
// - Phase 0 current word read returns the 16-bit measured current.
// - Store control byte: 0x01 copy stored to RAM, 0x02 store, 0x03 erase.
`ifndef FRPF_REGS_SVH
`define FRPF_REGS_SVH

`define FRPF_CMD_RECORD       8'hea
`define FRPF_CMD_UNSET_MAP    8'heb
`define FRPF_CMD_LISTEN_VEC   8'hf0
`define FRPF_CMD_IOUT0        8'hf2
`define FRPF_CMD_STORE_CTL    8'hf3

`define FRPF_LEN_RECORD       6'h20
`define FRPF_LEN_UNSET_MAP    6'h10
`define FRPF_LEN_LISTEN_VEC   6'h04
`define FRPF_LEN_IOUT0        6'h02
`define FRPF_LEN_BYTE         6'h01

`define FRPF_CTL_COPY_TO_RAM  8'h01
`define FRPF_CTL_STORE        8'h02
`define FRPF_CTL_ERASE        8'h03

`define FRPF_NVM_STAT_HI      183
`define FRPF_NVM_STAT_LO      176
`define FRPF_NVM_STAT_FROZEN  8'h00
`define FRPF_NVM_STAT_LIVE    8'hff

`define FRPF_LISTEN_RESET     32'h0000_0000
`define FRPF_UNSET_RESET      128'h0

`endif

// ### hdl/frpf_pkg.sv
// Purpose: Types shared by the fault record block
// Assumes: Used only by scoped reference
// Notes:   Peer reaction states
package frpf_pkg;
   typedef enum logic [1:0] {
      PEER_RUN,
      PEER_DOWN_FAST,
      PEER_DOWN_SEQ
   } frpf_peer_state_type;
endpackage

// ### hdl/frpf_peer_if.sv
// Purpose: Carries peer fault configuration and reactions between the bank and peer logic
// Assumes: One clock domain
// Notes:   Fault pins are raw and synchronised by the peer logic
`timescale 1ns/1ps
interface frpf_peer_if;
   logic [31:0]                      listen_vec;
   logic                             spread_en;
   logic                             seq_en;
   logic [31:0]                      peer_fault_pin;
   logic                             shutdown_now;
   logic                             seq_shutdown;
   logic                             restart_req;
   frpf_pkg::frpf_peer_state_type    state;

   modport ctl  (input listen_vec, spread_en, seq_en, peer_fault_pin,
                 output shutdown_now, seq_shutdown, restart_req, state);
   modport bank (output listen_vec, spread_en, seq_en, peer_fault_pin,
                 input shutdown_now, seq_shutdown, restart_req, state);
endinterface

// ### hdl/frpf_peer_ctl.sv
// Purpose: Reacts to faults spread by other rails of the group
// Assumes: Peer fault pins are asynchronous levels, one per group identifier
// Notes:   Restart waits until no listened peer still reports a fault
`timescale 1ns/1ps
module frpf_peer_ctl (
   input  wire logic  clk_sys,
   input  wire logic  reset_n,
   frpf_peer_if.ctl   pif
);
   logic [31:0]                    meta_r;
   logic [31:0]                    sync_r;
   logic [31:0]                    heard;
   logic                           any_heard;
   frpf_pkg::frpf_peer_state_type  state_r;
   frpf_pkg::frpf_peer_state_type  state_nxt;
   logic                           fast_r;
   logic                           seq_r;
   logic                           restart_r;

   always_ff @(posedge clk_sys) begin
      meta_r <= pif.peer_fault_pin;
      sync_r <= meta_r;
   end

   assign heard     = sync_r & pif.listen_vec;
   assign any_heard = |heard;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         frpf_pkg::PEER_RUN: begin
            if (any_heard && pif.spread_en) begin
               state_nxt = frpf_pkg::PEER_DOWN_FAST;
            end else if (any_heard && pif.seq_en) begin
               state_nxt = frpf_pkg::PEER_DOWN_SEQ;
            end
            // Neither mode set: peer faults leave the output alone
         end
         frpf_pkg::PEER_DOWN_FAST,
         frpf_pkg::PEER_DOWN_SEQ: begin
            if (!any_heard) begin
               state_nxt = frpf_pkg::PEER_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r   <= frpf_pkg::PEER_RUN;
         fast_r    <= 1'b0;
         seq_r     <= 1'b0;
         restart_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         fast_r    <= (state_nxt == frpf_pkg::PEER_DOWN_FAST);
         seq_r     <= (state_nxt == frpf_pkg::PEER_DOWN_SEQ);
         restart_r <= (state_r != frpf_pkg::PEER_RUN) && (state_nxt == frpf_pkg::PEER_RUN);
      end
   end

   assign pif.shutdown_now = fast_r;
   assign pif.seq_shutdown = seq_r;
   assign pif.restart_req  = restart_r;
   assign pif.state        = state_r;
endmodule

// ### verif/frpf_bank_monitor.sv
// Purpose: Port-level checks of the fault record bank
// Assumes: Sees only ports of frpf_bank, one clock domain
// Notes:   Bound into every frpf_bank instance
`timescale 1ns/1ps
`include "frpf_regs.svh"
module frpf_bank_monitor #(
   parameter int FAULT_W = 8
) (
   input wire logic               clk_sys,
   input wire logic               reset_n,
   input wire logic               cmd_strobe,
   input wire logic               cmd_write,
   input wire logic [7:0]         cmd_code,
   input wire logic [31:0]        cmd_wdata,
   input wire logic               rsp_valid,
   input wire logic               rsp_err,
   input wire logic [5:0]         rsp_len,
   input wire logic [255:0]       rsp_data,
   input wire logic [15:0]        iout0_meas,
   input wire logic [FAULT_W-1:0] fault_event,
   input wire logic [FAULT_W-1:0] record_trigger_mask,
   input wire logic               nvm_store,
   input wire logic               nvm_erase,
   input wire logic               record_frozen,
   input wire logic               own_output_off,
   input wire logic               share_all_off,
   input wire logic               peer_shutdown_now,
   input wire logic               peer_seq_shutdown,
   input wire logic               peer_restart_req,
   input wire logic               rail_shutdown
);
   wire ctl_wr  = cmd_strobe && cmd_write && cmd_code == `FRPF_CMD_STORE_CTL;
   wire trigger = |(fault_event & ~record_trigger_mask);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   a_rsp_cause: assert property (rsp_valid |-> $past(cmd_strobe))
      else $error("response without a request");
   a_record_len: assert property (rsp_valid && $past(cmd_code) == `FRPF_CMD_RECORD
      && !$past(cmd_write) |-> rsp_len == `FRPF_LEN_RECORD && !rsp_err)
      else $error("record read length wrong");
   a_nvm_status: assert property (rsp_valid && $past(cmd_code) == `FRPF_CMD_RECORD
      && !$past(cmd_write) |-> rsp_data[183:176] == ($past(record_frozen) ? 8'h00 : 8'hff))
      else $error("record status byte wrong");
   a_unset_len: assert property (rsp_valid && $past(cmd_code) == `FRPF_CMD_UNSET_MAP
      && !$past(cmd_write) |-> rsp_len == `FRPF_LEN_UNSET_MAP)
      else $error("unset map length wrong");
   a_iout0_word: assert property (rsp_valid && $past(cmd_code) == `FRPF_CMD_IOUT0
      && !$past(cmd_write) |-> rsp_len == `FRPF_LEN_IOUT0 && rsp_data[15:0] == $past(iout0_meas))
      else $error("phase current word wrong");
   a_fault_freeze: assert property (!record_frozen && trigger && !ctl_wr && $past(reset_n)
      |=> record_frozen && nvm_store)
      else $error("unmasked fault did not freeze");
   a_frozen_stays: assert property (record_frozen && !ctl_wr |=> record_frozen && !nvm_store)
      else $error("frozen record disturbed");
   a_store_code: assert property (ctl_wr && cmd_wdata[7:0] == `FRPF_CTL_STORE && $past(reset_n)
      |=> nvm_store && !rsp_err)
      else $error("store code not obeyed");
   a_erase_code: assert property (ctl_wr && cmd_wdata[7:0] == `FRPF_CTL_ERASE && $past(reset_n)
      |=> nvm_erase && (!record_frozen || $past(trigger)))
      else $error("erase code not obeyed");
   a_rail_both: assert property (rail_shutdown |-> $past(own_output_off, 3)
      && $past(share_all_off, 3))
      else $error("rail down before all sharers");
   a_restart_clear: assert property (peer_restart_req |-> !peer_shutdown_now
      && !peer_seq_shutdown && $past(peer_shutdown_now || peer_seq_shutdown))
      else $error("restart while still shut down");
   c_freeze: cover property ($rose(record_frozen));
   c_erase: cover property (nvm_erase);
   c_peer: cover property (peer_shutdown_now);
endmodule
bind frpf_bank frpf_bank_monitor #(.FAULT_W(FAULT_W)) mon (.*);

// ### verif/frpf_host_model.sv
// Purpose: Management bus host issuing decoded commands to the bank
// Assumes: Answer within a few cycles of the taking edge
// Notes:   Released command lines show inverted values, never stale ones
`timescale 1ns/1ps
module frpf_host_model (
   input  wire logic         clk_sys,
   output      logic         cmd_strobe,
   output      logic         cmd_write,
   output      logic [7:0]   cmd_code,
   output      logic [31:0]  cmd_wdata,
   input  wire logic         rsp_valid,
   input  wire logic         rsp_err,
   input  wire logic [5:0]   rsp_len,
   input  wire logic [255:0] rsp_data
);
   initial begin
      cmd_strobe = 1'b0;
      cmd_write  = 1'b0;
      cmd_code   = 8'h00;
      cmd_wdata  = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] code, input logic [31:0] d,
                       output logic err, output logic [5:0] len, output logic [255:0] data);
      int n;
      n = 0;
      @(posedge clk_sys);
      cmd_strobe <= 1'b1;
      cmd_write  <= w;
      cmd_code   <= code;
      cmd_wdata  <= d;
      @(posedge clk_sys);
      cmd_strobe <= 1'b0;
      cmd_write  <= ~w;
      cmd_code   <= ~code;
      cmd_wdata  <= ~d;
      #1;
      while (rsp_valid !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      err  = rsp_err;
      len  = rsp_len;
      data = rsp_data;
   endtask
endmodule

// ### verif/fault_record_and_peer_fault_group_test.sv
// Purpose: Self-checking bench of the fault record bank
// Assumes: Non-volatile store modelled here keeps its record over bench resets
// Notes:   A mid-run reset stands in for an input power cycle
`timescale 1ns/1ps
`include "frpf_regs.svh"
module fault_record_and_peer_fault_group_test;
   localparam logic [255:0] REC_A = {8{32'hc0de_0a5a}};
   localparam logic [255:0] REC_B = {8{32'h1357_9bdf}};
   logic clk_sys, reset_n, cmd_strobe, cmd_write, rsp_valid, rsp_err;
   logic nvm_store, nvm_erase, record_frozen, param_recall, param_write;
   logic nvm_record_valid = 1'b0;
   logic fault_spread_en, sequence_en, peer_shutdown_now, peer_seq_shutdown, peer_restart_req;
   logic own_output_off, share_all_off, rail_shutdown, r_err;
   logic [7:0]   cmd_code, fault_event, record_trigger_mask;
   logic [31:0]  cmd_wdata, peer_fault_pin;
   logic [5:0]   rsp_len, r_len;
   logic [15:0]  iout0_meas;
   logic [6:0]   param_index;
   logic [127:0] param_present;
   logic [255:0] rsp_data, live_record, nvm_store_data, r_data;
   logic [255:0] nvm_record = 256'h0;
   int           err_total, comparisons;
   int           restarts = 0;
   frpf_bank #(.FAULT_W(8)) uut (.*);
   frpf_host_model host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (nvm_store) begin
         nvm_record       <= nvm_store_data;
         nvm_record_valid <= 1'b1;
      end else if (nvm_erase) begin
         nvm_record_valid <= 1'b0;
      end
   end
   // Restart pulses last one cycle, so they are counted as they pass
   always @(posedge clk_sys) begin
      if (peer_restart_req === 1'b1) begin
         restarts <= restarts + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] code);
      host.xfer(1'b0, code, 32'h0, r_err, r_len, r_data);
      chk(256'(rsp_valid), 256'(1'b1));
   endtask
   task automatic wr(input logic [7:0] code, input logic [31:0] d);
      host.xfer(1'b1, code, d, r_err, r_len, r_data);
      chk(256'(rsp_valid), 256'(1'b1));
   endtask
   function automatic logic [255:0] stat(input logic [255:0] r, input logic [7:0] s);
      logic [255:0] v;
      v = r;
      v[183:176] = s;
      return v;
   endfunction
   task automatic pulse_fault(input logic [7:0] f);
      @(posedge clk_sys);
      fault_event <= f;
      @(posedge clk_sys);
      fault_event <= 8'h00;
      live_record <= REC_B;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_record();
      rd(`FRPF_CMD_RECORD);
      chk(256'(r_len), 256'(`FRPF_LEN_RECORD));
      chk(r_data, stat(REC_A, `FRPF_NVM_STAT_LIVE));
      tick(1);
      record_trigger_mask <= 8'h02;
      pulse_fault(8'h02);
      tick(2);
      rd(`FRPF_CMD_RECORD);
      chk(r_data, stat(REC_B, `FRPF_NVM_STAT_LIVE));
      tick(1);
      live_record <= REC_A;
      tick(2);
      pulse_fault(8'h01);
      tick(2);
      rd(`FRPF_CMD_RECORD);
      chk(r_data, stat(REC_A, `FRPF_NVM_STAT_FROZEN));
      chk(nvm_record, REC_A);
      pulse_fault(8'h81);
      tick(2);
      chk(nvm_record, REC_A);
      reset_n <= 1'b0;
      tick(3);
      reset_n <= 1'b1;
      tick(3);
      rd(`FRPF_CMD_RECORD);
      chk(r_data, stat(REC_A, `FRPF_NVM_STAT_FROZEN));
      $display("record capture test done");
   endtask
   task automatic t_store_ctl();
      wr(`FRPF_CMD_STORE_CTL, 32'h03);
      tick(2);
      rd(`FRPF_CMD_RECORD);
      chk(r_data, stat(REC_B, `FRPF_NVM_STAT_LIVE));
      chk(256'(nvm_record_valid), 256'(1'b0));
      wr(`FRPF_CMD_STORE_CTL, 32'h02);
      tick(2);
      chk(nvm_record, REC_B);
      live_record <= REC_A;
      wr(`FRPF_CMD_STORE_CTL, 32'h01);
      tick(2);
      rd(`FRPF_CMD_RECORD);
      chk(r_data, stat(REC_B, `FRPF_NVM_STAT_FROZEN));
      rd(`FRPF_CMD_STORE_CTL);
      chk(256'(r_len), 256'(`FRPF_LEN_BYTE));
      wr(`FRPF_CMD_STORE_CTL, 32'h04);
      chk(256'(r_err), 256'(1'b1));
      wr(`FRPF_CMD_RECORD, 32'h0);
      chk(256'(r_err), 256'(1'b1));
      $display("store control test done");
   endtask
   task automatic t_map_and_vec();
      @(posedge clk_sys);
      param_present <= {4{32'h7fff_00f0}};
      param_recall  <= 1'b1;
      @(posedge clk_sys);
      param_recall <= 1'b0;
      param_write  <= 1'b1;
      param_index  <= 7'h7f;
      @(posedge clk_sys);
      param_write <= 1'b0;
      rd(`FRPF_CMD_UNSET_MAP);
      chk(256'(r_len), 256'(`FRPF_LEN_UNSET_MAP));
      chk(r_data, 256'({1'b0, ~param_present[126:0]}));
      wr(`FRPF_CMD_LISTEN_VEC, 32'h8000_0003);
      rd(`FRPF_CMD_LISTEN_VEC);
      chk(r_data, 256'(32'h8000_0003));
      rd(`FRPF_CMD_IOUT0);
      chk(r_data, 256'(16'h9abc));
      $display("map and vector test done");
   endtask
   task automatic peer(input logic s, input logic q, input logic [31:0] p,
                       input logic fast, input logic seq);
      @(posedge clk_sys);
      fault_spread_en <= s;
      sequence_en     <= q;
      peer_fault_pin  <= p;
      tick(6);
      chk(256'({peer_shutdown_now, peer_seq_shutdown}), 256'({fast, seq}));
   endtask
   task automatic t_peer();
      peer(1'b1, 1'b0, 32'h0000_0004, 1'b0, 1'b0);
      peer(1'b1, 1'b0, 32'h8000_0004, 1'b1, 1'b0);
      peer(1'b1, 1'b0, 32'h0000_0001, 1'b1, 1'b0);
      peer(1'b1, 1'b0, 32'h0000_0000, 1'b0, 1'b0);
      peer(1'b0, 1'b1, 32'h0000_0002, 1'b0, 1'b1);
      peer(1'b0, 1'b1, 32'h0000_0000, 1'b0, 1'b0);
      peer(1'b0, 1'b0, 32'h0000_0003, 1'b0, 1'b0);
      own_output_off <= 1'b1;
      tick(5);
      chk(256'(rail_shutdown), 256'(1'b0));
      share_all_off <= 1'b1;
      tick(5);
      chk(256'(rail_shutdown), 256'(1'b1));
      chk(256'(restarts), 256'(2));
      $display("peer fault test done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      {fault_event, record_trigger_mask, param_recall, param_write} = '0;
      {fault_spread_en, sequence_en, peer_fault_pin, own_output_off, share_all_off} = '0;
      {param_index, param_present} = '0;
      live_record = REC_A;
      iout0_meas = 16'h9abc;
      tick(12);
      reset_n <= 1'b1;
      tick(2);
      t_record();
      t_store_ctl();
      t_map_and_vec();
      t_peer();
      finish_test();
   end
   initial begin
      tick(5000);
      err_total++;
      finish_test();
   end
endmodule
